// [verilog/strobe_delay_pkg.sv]
// Contract
// - Twelve pins form one strobe group; two fixed pins carry the strobe pair.
// - Incoming strobe is delayed by a programmable line before capturing data.
// - Read delay line is a slave calibrated by the master loop.
// - A nine-bit calibration code arrives from the master loop.
// - A second delay line makes phased write clocks for data and strobe.
// - A third delay line gives an adjustable write-leveling delay.
// - Read and write delays adjust at run time from core margin inputs.
// - Block generates read and write pointers for the input FIFO.
// - FIFO read pointer is three bits, shared by every cell in the group.
// - Pause stops the edge clock; core pauses for leveling and code updates.
// - Four-bit read clock select picks read clock source and polarity.
// - Read direction 0 raises the read code, 1 lowers it.
// - Enable 1, load select 0: move pulse loads signed nine-bit preload.
// - Load select 1: each move pulse steps counter per read direction.
// - Move pulse plus edge clock make one step of exactly one count.
// - Reset input clears strobe control logic in all operating modes.
// - Clock choice selects read delay cell output or slow system clock.
// - Write direction 0 raises the write code, 1 lowers it.
// - Dedicated input resets the smoothing counters of all three delays.
// - Block outputs a data-valid flag qualifying read data.
package strobe_delay_pkg;

  localparam int        GROUP_PINS   = 12;
  localparam int        STROBE_P_IDX = 0;
  localparam int        STROBE_N_IDX = 1;
  localparam int        CAL_W        = 9;
  localparam int        OFS_W        = 10;
  localparam int        PTR_W        = 3;
  localparam int        SEL_W        = 4;
  localparam int        READ_W       = 4;
  localparam int        TAP_W        = 4;
  localparam int        TAP_DEPTH    = 16;
  localparam int        SYNC_STAGES  = 3;
  localparam int        NUM_CH       = 3;
  localparam int        CH_READ      = 0;
  localparam int        CH_WRITE     = 1;
  localparam int        CH_LEVEL     = 2;
  localparam int        SCLK_DIV_W   = 2;
  localparam int        SMOOTH_W     = 3;
  localparam logic [2:0] SMOOTH_LAST = 3'h7;
  localparam logic [8:0] CODE_MAX    = 9'h1ff;
  localparam logic [9:0] OFS_RESET   = 10'h000;
  localparam logic [9:0] OFS_POS_MAX = 10'h1ff;
  localparam logic [9:0] OFS_NEG_MAX = 10'h201;
  localparam logic [2:0] PTR_RESET   = 3'h0;
  localparam logic [3:0] DQ_TAP_SHIFT = 4'h4;
  localparam logic [3:0] TAP_LAST    = 4'hf;

endpackage : strobe_delay_pkg

// [verilog/margin_counter.sv]
`timescale 1ns/1ps
`default_nettype none
module margin_counter (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             srst,
  // Control
  input  wire logic             smoothRst,
  input  wire logic             marginEn,
  input  wire logic             loadN,
  input  wire logic             step,
  input  wire logic             dir,
  input  wire logic             preSign,
  input  wire logic [8:0]       preMag,
  // Result
  output logic signed [9:0]     applied_r,
  output logic                  overflow_r
);

  logic signed [9:0] offset_r;
  logic signed [9:0] offset_nxt;
  logic signed [9:0] applied_nxt;
  logic              overflow_nxt;
  logic [2:0]        smooth_r;
  logic [2:0]        smooth_nxt;

  always_comb begin
    offset_nxt   = offset_r;
    overflow_nxt = overflow_r;
    applied_nxt  = applied_r;
    smooth_nxt   = smooth_r + 3'h1;
    if (step && marginEn) begin
      if (!loadN) begin
        // Sign-magnitude preload turned into two's complement
        offset_nxt = preSign ? -$signed({1'b0, preMag})
                             : $signed({1'b0, preMag});
      end else if (!dir) begin
        if (offset_r == $signed(strobe_delay_pkg::OFS_POS_MAX)) begin
          overflow_nxt = 1'b1;
        end else begin
          offset_nxt = offset_r + 10'sd1;
        end
      end else begin
        if (offset_r == $signed(strobe_delay_pkg::OFS_NEG_MAX)) begin
          overflow_nxt = 1'b1;
        end else begin
          offset_nxt = offset_r - 10'sd1;
        end
      end
    end
    // Applied code walks one count per smoothing period to avoid glitches
    if (smoothRst) begin
      smooth_nxt  = '0;
      applied_nxt = offset_r;
    end else if (smooth_r == strobe_delay_pkg::SMOOTH_LAST) begin
      if (applied_r < offset_r) begin
        applied_nxt = applied_r + 10'sd1;
      end else if (applied_r > offset_r) begin
        applied_nxt = applied_r - 10'sd1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      offset_r   <= strobe_delay_pkg::OFS_RESET;
      applied_r  <= strobe_delay_pkg::OFS_RESET;
      overflow_r <= 1'b0;
      smooth_r   <= '0;
    end else begin
      offset_r   <= offset_nxt;
      applied_r  <= applied_nxt;
      overflow_r <= overflow_nxt;
      smooth_r   <= smooth_nxt;
    end
  end

endmodule : margin_counter
`default_nettype wire

// [verilog/strobe_delay_block.sv]
`timescale 1ns/1ps
`default_nettype none
module strobe_delay_block (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Pins from outside the clock domain
  input  wire logic        strobeInput,
  input  wire logic        edgeClockIn,
  // Calibration from the master loop
  input  wire logic [8:0]  calibrationCode,
  // Core control
  input  wire logic        pause,
  input  wire logic [3:0]  readClockSelect,
  input  wire logic [3:0]  readIndication,
  input  wire logic        captureClockChoice,
  input  wire logic        smoothingCounterReset,
  // Read margin
  input  wire logic        readMarginEnable,
  input  wire logic        readPreloadSelectN,
  input  wire logic        readStepPulse,
  input  wire logic        readStepDirection,
  input  wire logic        readPreloadSign,
  input  wire logic [8:0]  readPreloadMagnitude,
  // Write margin
  input  wire logic        writeMarginEnable,
  input  wire logic        writePreloadSelectN,
  input  wire logic        writeStepPulse,
  input  wire logic        writeStepDirection,
  input  wire logic        writePreloadSign,
  input  wire logic [8:0]  writePreloadMagnitude,
  // Write-leveling margin
  input  wire logic        levelMarginEnable,
  input  wire logic        levelPreloadSelectN,
  input  wire logic        levelStepPulse,
  input  wire logic        levelStepDirection,
  // Clocks to the cells
  output logic             captureStrobe_r,
  output logic             captureClock_r,
  output logic             readClock_r,
  output logic             strobeWriteClock_r,
  output logic             dataWriteClock_r,
  output logic             levelClock_r,
  output logic             edgeClockOut_r,
  // FIFO control and status
  output logic [2:0]       fifoReadPointer_r,
  output logic [2:0]       fifoWritePointer_r,
  output logic             readValidFlag_r,
  output logic             readOverflow_r,
  output logic [8:0]       readCode_r,
  output logic [11:0]      strobePinMap_r
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam int NPIN = 2;
  logic [2:0] pinSync_r   [NPIN];
  logic [2:0] pinSync_nxt [NPIN];
  logic [NPIN-1:0] pinLevel_r;
  logic [NPIN-1:0] pinLevel_nxt;
  logic [NPIN-1:0] pinRaw;

  assign pinRaw = {edgeClockIn, strobeInput};

  genvar gp;
  generate
    for (gp = 0; gp < NPIN; gp++) begin : g_pin
      always_comb begin
        pinSync_nxt[gp]  = {pinSync_r[gp][1:0], pinRaw[gp]};
        pinLevel_nxt[gp] = pinLevel_r[gp];
        // Change taken only once stages two and three agree
        if (pinSync_r[gp][1] == pinSync_r[gp][2]) begin
          pinLevel_nxt[gp] = pinSync_r[gp][2];
        end
      end
      always_ff @(posedge mclk) begin
        if (srst) begin
          pinSync_r[gp]  <= '0;
          pinLevel_r[gp] <= 1'b0;
        end else begin
          pinSync_r[gp]  <= pinSync_nxt[gp];
          pinLevel_r[gp] <= pinLevel_nxt[gp];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Edge clock gating and slow clock divider
  // ****************************************************************
  logic       eclkGated_nxt;
  logic       eclkRise;
  logic [1:0] sclkDiv_r;
  logic [1:0] sclkDiv_nxt;
  logic       sysClk;

  always_comb begin
    eclkGated_nxt = pinLevel_r[1] & ~pause;
    eclkRise      = eclkGated_nxt & ~edgeClockOut_r;
    sclkDiv_nxt   = sclkDiv_r + 2'h1;
    sysClk        = sclkDiv_r[strobe_delay_pkg::SCLK_DIV_W-1];
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      edgeClockOut_r <= 1'b0;
      sclkDiv_r      <= '0;
    end else begin
      edgeClockOut_r <= eclkGated_nxt;
      sclkDiv_r      <= sclkDiv_nxt;
    end
  end

  // ****************************************************************
  // Margin counters, one per delay line
  // ****************************************************************
  logic [2:0] movePulse;
  logic [2:0] moveDir;
  logic [2:0] moveEn;
  logic [2:0] moveLoadN;
  logic [2:0] moveStep;
  logic [2:0] moveDone_r;
  logic [2:0] moveDone_nxt;
  logic       moveSign    [3];
  logic [8:0] moveMag     [3];
  logic signed [9:0] chOffset [3];
  logic [2:0] chOverflow;

  assign movePulse = {levelStepPulse, writeStepPulse, readStepPulse};
  assign moveDir   = {levelStepDirection, writeStepDirection,
                      readStepDirection};
  assign moveEn    = {levelMarginEnable, writeMarginEnable,
                      readMarginEnable};
  assign moveLoadN = {levelPreloadSelectN, writePreloadSelectN,
                      readPreloadSelectN};
  assign moveSign[0] = readPreloadSign;
  assign moveSign[1] = writePreloadSign;
  assign moveSign[2] = 1'b0;
  assign moveMag[0]  = readPreloadMagnitude;
  assign moveMag[1]  = writePreloadMagnitude;
  // Leveling load clears its counter to zero
  assign moveMag[2]  = 9'h000;

  genvar gc;
  generate
    for (gc = 0; gc < strobe_delay_pkg::NUM_CH; gc++) begin : g_ch
      always_comb begin
        // One step per pulse, aligned to an edge-clock rise
        moveStep[gc]     = movePulse[gc] & ~moveDone_r[gc] & eclkRise;
        moveDone_nxt[gc] = movePulse[gc] & (moveDone_r[gc] | eclkRise);
      end
      always_ff @(posedge mclk) begin
        if (srst) begin
          moveDone_r[gc] <= 1'b0;
        end else begin
          moveDone_r[gc] <= moveDone_nxt[gc];
        end
      end
      margin_counter u_cnt (
        .mclk       (mclk),
        .srst       (srst),
        .smoothRst  (smoothingCounterReset),
        .marginEn   (moveEn[gc]),
        .loadN      (moveLoadN[gc]),
        .step       (moveStep[gc]),
        .dir        (moveDir[gc]),
        .preSign    (moveSign[gc]),
        .preMag     (moveMag[gc]),
        .applied_r  (chOffset[gc]),
        .overflow_r (chOverflow[gc])
      );
    end
  endgenerate

  // ****************************************************************
  // Delay codes: calibration plus margin offset, saturated
  // ****************************************************************
  function automatic logic [8:0] addCode(input logic [8:0] base,
                                         input logic signed [9:0] ofs);
    logic signed [11:0] sum;
    sum = $signed({3'b000, base}) + $signed({{2{ofs[9]}}, ofs});
    if (sum < 12'sd0) begin
      addCode = 9'h000;
    end else if (sum > $signed({3'b000, strobe_delay_pkg::CODE_MAX})) begin
      addCode = strobe_delay_pkg::CODE_MAX;
    end else begin
      addCode = sum[8:0];
    end
  endfunction : addCode

  function automatic logic [3:0] satTap(input logic [3:0] a,
                                        input logic [3:0] b);
    logic [4:0] s;
    s = {1'b0, a} + {1'b0, b};
    satTap = s[4] ? strobe_delay_pkg::TAP_LAST : s[3:0];
  endfunction : satTap

  logic [8:0] readCode;
  logic [8:0] writeCode;
  logic [8:0] levelCode;
  logic [3:0] readTap;
  logic [3:0] writeTap;
  logic [3:0] levelTap;
  logic [3:0] selTap;

  always_comb begin
    // Slave lines take their scale from the master loop's code
    readCode  = addCode(calibrationCode, chOffset[0]);
    writeCode = addCode(calibrationCode, chOffset[1]);
    levelCode = addCode(calibrationCode, chOffset[2]);
    readTap   = readCode[8:5];
    writeTap  = writeCode[8:5];
    levelTap  = levelCode[8:5];
    selTap    = satTap(readTap, {1'b0, readClockSelect[3:1]});
  end

  // ****************************************************************
  // Tapped delay lines
  // ****************************************************************
  logic [15:0] strobeLine_r;
  logic [15:0] strobeLine_nxt;
  logic [15:0] eclkLine_r;
  logic [15:0] eclkLine_nxt;
  logic        capture_nxt;
  logic        captureRise;

  always_comb begin
    strobeLine_nxt = {strobeLine_r[14:0], pinLevel_r[0]};
    eclkLine_nxt   = {eclkLine_r[14:0], edgeClockOut_r};
    capture_nxt    = strobeLine_r[readTap];
    captureRise    = capture_nxt & ~captureStrobe_r;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      strobeLine_r       <= '0;
      eclkLine_r         <= '0;
      captureStrobe_r    <= 1'b0;
      captureClock_r     <= 1'b0;
      readClock_r        <= 1'b0;
      strobeWriteClock_r <= 1'b0;
      dataWriteClock_r   <= 1'b0;
      levelClock_r       <= 1'b0;
      readCode_r         <= '0;
      readOverflow_r     <= 1'b0;
    end else begin
      strobeLine_r       <= strobeLine_nxt;
      eclkLine_r         <= eclkLine_nxt;
      captureStrobe_r    <= capture_nxt;
      captureClock_r     <= captureClockChoice ? sysClk : capture_nxt;
      readClock_r        <= strobeLine_r[selTap] ^ readClockSelect[0];
      strobeWriteClock_r <= eclkLine_r[writeTap];
      dataWriteClock_r   <=
        eclkLine_r[satTap(writeTap, strobe_delay_pkg::DQ_TAP_SHIFT)];
      levelClock_r       <= eclkLine_r[levelTap];
      readCode_r         <= readCode;
      readOverflow_r     <= chOverflow[0];
    end
  end

  // ****************************************************************
  // FIFO pointers and data valid
  // ****************************************************************
  logic       readActive;
  logic [2:0] wrPtr_nxt;
  logic [2:0] rdPtr_nxt;
  logic       valid_nxt;

  always_comb begin
    readActive = |readIndication;
    wrPtr_nxt  = fifoWritePointer_r;
    rdPtr_nxt  = fifoReadPointer_r;
    valid_nxt  = 1'b0;
    if (captureRise) begin
      wrPtr_nxt = fifoWritePointer_r + 3'h1;
    end
    // Drain only entries already written; avoids reading stale cells
    if (eclkRise && readActive &&
        (fifoReadPointer_r != fifoWritePointer_r)) begin
      rdPtr_nxt = fifoReadPointer_r + 3'h1;
      valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      fifoWritePointer_r <= strobe_delay_pkg::PTR_RESET;
      fifoReadPointer_r  <= strobe_delay_pkg::PTR_RESET;
      readValidFlag_r    <= 1'b0;
      strobePinMap_r     <= '0;
    end else begin
      fifoWritePointer_r <= wrPtr_nxt;
      fifoReadPointer_r  <= rdPtr_nxt;
      readValidFlag_r    <= valid_nxt;
      strobePinMap_r     <=
        12'h001 << strobe_delay_pkg::STROBE_P_IDX |
        12'h001 << strobe_delay_pkg::STROBE_N_IDX;
    end
  end

endmodule : strobe_delay_block
`default_nettype wire

// [test/strobe_delay_props.sv]
`timescale 1ns/1ps
`default_nettype none
module strobe_delay_props (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        srst,
  // Inputs watched
  input wire logic        pause,
  input wire logic        smoothingCounterReset,
  input wire logic [8:0]  calibrationCode,
  // Outputs watched
  input wire logic        edgeClockOut_r,
  input wire logic [2:0]  fifoReadPointer_r,
  input wire logic        readValidFlag_r,
  input wire logic        readOverflow_r,
  input wire logic [8:0]  readCode_r,
  input wire logic [11:0] strobePinMap_r
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  // ****
  // Properties
  // ****
  a_pause_gates_edge: assert property (
    pause [*2] |=> !edgeClockOut_r) else $error("edge clock ran in pause");
  a_valid_ptr_step: assert property (
    readValidFlag_r |-> fifoReadPointer_r == $past(fifoReadPointer_r) + 3'h1)
    else $error("read pointer did not advance with valid");
  a_ptr_hold: assert property (
    !readValidFlag_r |-> $stable(fifoReadPointer_r))
    else $error("read pointer moved without valid");
  a_valid_single: assert property (
    readValidFlag_r |=> !readValidFlag_r) else $error("valid held too long");
  a_code_after_reset: assert property (
    $fell(srst) |-> ##[0:2] readCode_r == calibrationCode)
    else $error("offset not zero after reset");
  a_pin_map_set: assert property (
    $fell(srst) |-> ##[0:1] strobePinMap_r == 12'h003)
    else $error("strobe pair pins wrong");
  // Snap and reset jumps are excluded for five cycles
  a_code_one_step: assert property (
    (!srst && !smoothingCounterReset && $stable(calibrationCode)) [*5] |->
      readCode_r == $past(readCode_r) ||
      readCode_r == $past(readCode_r) + 9'h001 ||
      readCode_r == $past(readCode_r) - 9'h001)
    else $error("read code jumped");
  a_overflow_sticky: assert property (
    readOverflow_r |=> readOverflow_r) else $error("overflow cleared");
  c_valid: cover property (readValidFlag_r);
  c_overflow: cover property ($rose(readOverflow_r));
  c_pause: cover property (pause [*2] ##1 !pause);
endmodule : strobe_delay_props
bind strobe_delay_block strobe_delay_props u_props (.*);
`default_nettype wire

// [test/strobe_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module strobe_mem_model (
  // Burst request from the bench
  input  wire logic       burstGo,
  input  wire logic [3:0] burstBeats,
  input  wire logic       slowBeat,
  // Strobe pin toward the block
  output logic            strobeOut
);
  // Pin is terminated low, so it rests low between bursts
  initial strobeOut = 1'b0;
  always @(posedge burstGo) begin
    repeat (burstBeats) begin
      #(slowBeat ? 48 : 24) strobeOut = 1'b1;
      #(slowBeat ? 48 : 24) strobeOut = 1'b0;
    end
  end
endmodule : strobe_mem_model
`default_nettype wire

// [test/strobe_delay_block_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module strobe_delay_block_tb_top;
  // ****
  // Signals
  // ****
  logic        mclk = 1'b0, srst = 1'b1, edgeClk = 1'b0, pause = 1'b0;
  logic        capSel = 1'b0, smRst = 1'b0, go = 1'b0, slow = 1'b0;
  logic        rSgn = 1'b0, wSgn = 1'b0;
  logic [2:0]  en = 3'h0, ldN = 3'h0, pul = 3'h0, dir = 3'h0;
  logic [3:0]  rdSel = 4'h0, rdInd = 4'h0, beats = 4'h0;
  logic [8:0]  cal = 9'h040, rMag = 9'h000, wMag = 9'h010;
  wire logic   strobe;
  logic        capStb, capClk, rdClk, sWr, dWr, lvClk, eOut, vld, ovf;
  logic [2:0]  rPtr, wPtr;
  logic [8:0]  code;
  logic [11:0] pinMap;
  int          bad_count = 0, check_count = 0, n;

  always #2 mclk = ~mclk;
  // Link clock free runs with its own phase
  initial begin
    #7;
    forever #24 edgeClk = ~edgeClk;
  end

  strobe_delay_block u_dut (
    .mclk(mclk), .srst(srst), .strobeInput(strobe), .edgeClockIn(edgeClk),
    .calibrationCode(cal), .pause(pause), .readClockSelect(rdSel),
    .readIndication(rdInd), .captureClockChoice(capSel),
    .smoothingCounterReset(smRst), .readMarginEnable(en[0]),
    .readPreloadSelectN(ldN[0]), .readStepPulse(pul[0]),
    .readStepDirection(dir[0]), .readPreloadSign(rSgn),
    .readPreloadMagnitude(rMag), .writeMarginEnable(en[1]),
    .writePreloadSelectN(ldN[1]), .writeStepPulse(pul[1]),
    .writeStepDirection(dir[1]), .writePreloadSign(wSgn),
    .writePreloadMagnitude(wMag), .levelMarginEnable(en[2]),
    .levelPreloadSelectN(ldN[2]), .levelStepPulse(pul[2]),
    .levelStepDirection(dir[2]), .captureStrobe_r(capStb),
    .captureClock_r(capClk), .readClock_r(rdClk), .strobeWriteClock_r(sWr),
    .dataWriteClock_r(dWr), .levelClock_r(lvClk), .edgeClockOut_r(eOut),
    .fifoReadPointer_r(rPtr), .fifoWritePointer_r(wPtr),
    .readValidFlag_r(vld), .readOverflow_r(ovf), .readCode_r(code),
    .strobePinMap_r(pinMap));

  // Memory model drives only the strobe pin; no data pins are modelled
  strobe_mem_model u_mem (.burstGo(go), .burstBeats(beats),
    .slowBeat(slow), .strobeOut(strobe));

  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [11:0] ex,
                     input logic [11:0] got);
    check_count++;
    if (got !== ex) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic toggles(ref logic s, input int cyc, output int c);
    logic last;
    c = 0;
    last = s;
    repeat (cyc) begin
      tick(1);
      if (s !== last)
        c++;
      last = s;
    end
  endtask : toggles

  // Pulse spans more than one link period so one edge rise lands whenever pause is low
  task automatic move(input int ch, input logic l, input logic d);
    ldN[ch] = l;
    dir[ch] = d;
    pul[ch] = 1'b1;
    tick(14);
    pul[ch] = 1'b0;
    tick(6);
  endtask : move

  task automatic waitCode(input logic [8:0] ex);
    for (int i = 0; i < 600 && code !== ex; i++)
      tick(1);
    chk("readCode", 12'(ex), 12'(code));
    if (code !== ex)
      report_and_stop();
  endtask : waitCode

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  initial begin
    tick(3);
    srst = 1'b0;
    tick(4);
    chk("pinMap", 12'h003, pinMap);
    chk("readCode", 12'(cal), 12'(code));
    chk("readPtr", 12'h000, 12'(rPtr));
    $display("test reset done");
    en = 3'h7;
    rMag = 9'h005;
    move(0, 1'b0, 1'b0);
    waitCode(cal + 9'h005);
    repeat (3) move(0, 1'b1, 1'b0);
    waitCode(cal + 9'h008);
    move(0, 1'b1, 1'b1);
    waitCode(cal + 9'h007);
    en[0] = 1'b0;
    move(0, 1'b1, 1'b0);
    tick(40);
    chk("readCode", 12'(cal + 9'h007), 12'(code));
    en[0] = 1'b1;
    rSgn = 1'b1;
    rMag = 9'h020;
    move(0, 1'b0, 1'b0);
    waitCode(cal - 9'h020);
    $display("test read margin done");
    rSgn = 1'b0;
    rMag = 9'h1ff;
    smRst = 1'b1;
    move(0, 1'b0, 1'b0);
    chk("readCode", 12'h1ff, 12'(code));
    chk("overflow", 12'h000, 12'(ovf));
    move(0, 1'b1, 1'b0);
    chk("overflow", 12'h001, 12'(ovf));
    rMag = 9'h000;
    move(0, 1'b0, 1'b0);
    chk("readCode", 12'(cal), 12'(code));
    smRst = 1'b0;
    $display("test smoothing done");
    pause = 1'b1;
    move(0, 1'b1, 1'b0);
    toggles(eOut, 60, n);
    chk("edgeToggles", 12'h000, 12'(n));
    chk("readCode", 12'(cal), 12'(code));
    pause = 1'b0;
    toggles(eOut, 60, n);
    chk("edgeRuns", 12'h001, 12'(n != 0));
    move(1, 1'b0, 1'b0);
    move(1, 1'b1, 1'b1);
    move(2, 1'b0, 1'b0);
    move(2, 1'b1, 1'b0);
    toggles(sWr, 60, n);
    chk("strobeWrClk", 12'h001, 12'(n != 0));
    toggles(dWr, 60, n);
    chk("dataWrClk", 12'h001, 12'(n != 0));
    toggles(lvClk, 60, n);
    chk("levelClk", 12'h001, 12'(n != 0));
    // Strobe idles low here, so the read clock shows only its polarity
    for (int i = 0; i < 16; i++) begin
      rdSel = 4'(i);
      tick(2);
      chk("readClkPol", 12'(i % 2), 12'(rdClk));
    end
    capSel = 1'b1;
    tick(4);
    toggles(capClk, 16, n);
    chk("slowClk", 12'h008, 12'(n));
    capSel = 1'b0;
    $display("test clocks done");
    beats = 4'h4;
    go = 1'b1;
    toggles(capStb, 200, n);
    chk("captureStrobe", 12'h008, 12'(n));
    chk("writePtr", 12'h004, 12'(wPtr));
    chk("readPtr", 12'h000, 12'(rPtr));
    rdInd = 4'h1;
    toggles(vld, 120, n);
    chk("validEdges", 12'h008, 12'(n));
    chk("readPtr", 12'h004, 12'(rPtr));
    go = 1'b0;
    slow = 1'b1;
    tick(1);
    go = 1'b1;
    toggles(vld, 400, n);
    chk("writePtr", 12'h000, 12'(wPtr));
    chk("readPtr", 12'h000, 12'(rPtr));
    $display("test fifo done");
    srst = 1'b1;
    tick(3);
    srst = 1'b0;
    tick(4);
    chk("overflow", 12'h000, 12'(ovf));
    chk("readCode", 12'(cal), 12'(code));
    chk("pinMap", 12'h003, pinMap);
    $display("test second reset done");
    report_and_stop();
  end
endmodule : strobe_delay_block_tb_top
`default_nettype wire
